// ---- rtl/gsp_ctrl.sv ----
// Pin readback registers plus soft power-button countdown control.
// Assumes one clock, synchronous active-low reset, pins from outside.
//
// Functional notes
// - Writing one to the abort bit stops the countdown with no power-down; the bit itself is not stored.
// - The abort bit reads 0 while the countdown runs and 1 once it is stopped.
// - Writing one to the rearm bit restarts the full programmed delay, and the bit clears itself.
// - Rearm requests are accepted without limit, each restarting the delay again.
// - Writing one to the force bit starts a power-down at once, and the bit clears itself.
// - The countdown length comes from the delay-setting register at index B8.
// - Index F6 reads the eight group-1 pin levels, pin n in bit n.
// - Index F9 reads the five group-5 pin levels in bits 0 to 4.
// - Bits 7 to 5 of the group-5 readback carry no pin.
// - Index FA reads the eight group-6 pin levels, pin n in bit n.
// - Outside configuration mode the readbacks, control and soft power registers alias at 01 to 06.
// - Each group-1 pin can be enabled onto the first combined interrupt.
// - Each group-5 and group-6 pin can be enabled onto the second combined interrupt.
// - The control bits sit in the control register at F4, whose bit 0 is the watchdog status flag.
`default_nettype none
module gsp_ctrl
  import gsp_pkg::*;
#(
  parameter int UNIT_CYCLES = gsp_pkg::UNIT_CYCLES_DFLT
) (
  input  wire logic       core_clk,       // System clock
  input  wire logic       rstn,           // Synchronous reset, active low
  input  wire logic       ce,             // Clock enable, freezes state
  input  wire logic       cfg_mode,       // High in configuration mode
  input  wire logic [7:0] reg_idx,        // Register index
  input  wire logic [7:0] reg_wdata,      // Write data
  input  wire logic       reg_wr,         // Write strobe
  input  wire logic       reg_rd,         // Read strobe
  output logic      [7:0] reg_rdata,      // Read data, next cycle
  input  wire logic [7:0] group1_pins,    // Group-1 pin levels
  input  wire logic [4:0] group5_pins,    // Group-5 pin levels
  input  wire logic [7:0] group6_pins,    // Group-6 pin levels
  input  wire logic       power_button_n, // Power button, active low
  input  wire logic       wdt_timeout,    // Watchdog expiry pulse
  output logic            power_down,     // One-cycle power-down pulse
  output logic            combined_pin_irq_a, // Group-1 combined irq
  output logic            combined_pin_irq_b  // Group-5/6 combined irq
);
  import gsp_pkg::*;

  localparam int PW = $clog2(UNIT_CYCLES + 1);

  if (UNIT_CYCLES < 1) begin : g_chk
    $error("UNIT_CYCLES must be at least one");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } gsp_cnt_t;

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [21:0] pin_s1_r, pin_s2_r;
  logic        btn_prev_r;
  logic [7:0]  g1_s, g6_s;
  logic [4:0]  g5_s;
  logic        btn_s;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      // Button lane resets to its released level, so no false press
      // (and no spurious countdown) follows the release of reset
      pin_s1_r   <= 22'h200000;
      pin_s2_r   <= 22'h200000;
      btn_prev_r <= 1'b1;
    end else if (ce) begin
      pin_s1_r   <= {power_button_n, group6_pins, group5_pins, group1_pins};
      pin_s2_r   <= pin_s1_r;
      btn_prev_r <= pin_s2_r[21];
    end
  end

  assign g1_s  = pin_s2_r[7:0];
  assign g5_s  = pin_s2_r[12:8];
  assign g6_s  = pin_s2_r[20:13];
  assign btn_s = pin_s2_r[21];

  // ****************************************************
  // Index decode
  // ****************************************************
  logic [7:0] eff_idx;

  always_comb begin
    eff_idx = reg_idx;
    if (!cfg_mode) begin
      unique case (reg_idx)
        RT_G1_LVL:  eff_idx = IDX_G1_LVL;
        RT_CTRL:    eff_idx = IDX_CTRL;
        RT_G5_LVL:  eff_idx = IDX_G5_LVL;
        RT_G6_LVL:  eff_idx = IDX_G6_LVL;
        RT_SP_EN:   eff_idx = IDX_SP_EN;
        RT_SP_STAT: eff_idx = IDX_SP_STAT;
        default:    eff_idx = IDX_NONE;
      endcase
    end
  end

  logic wr_ctrl, abort_req, rearm_req, force_req, btn_fall;
  assign wr_ctrl   = reg_wr && (eff_idx == IDX_CTRL);
  assign abort_req = wr_ctrl && reg_wdata[CTRL_ABORT];
  assign rearm_req = wr_ctrl && reg_wdata[CTRL_REARM];
  assign force_req = wr_ctrl && reg_wdata[CTRL_FORCE];
  assign btn_fall  = btn_prev_r && !btn_s;

  // ****************************************************
  // Registers and countdown
  // ****************************************************
  gsp_cnt_t       state_r, state_nxt;
  logic [PW-1:0]  pre_r, pre_nxt;
  logic [7:0]     unit_r, unit_nxt;
  logic [7:0]     delay_r, delay_nxt;
  logic [3:0]     ctrl_r, ctrl_nxt;
  logic [7:0]     en1_r, en1_nxt, en6_r, en6_nxt;
  logic [4:0]     en5_r, en5_nxt;
  logic           spen_r, spen_nxt;
  logic [1:0]     stat_r, stat_nxt;
  logic           pd_nxt, irqa_nxt, irqb_nxt;
  logic [7:0]     rd_mux, rdata_nxt;

  always_comb begin
    state_nxt = state_r;
    pre_nxt   = pre_r;
    unit_nxt  = unit_r;
    delay_nxt = delay_r;
    ctrl_nxt  = ctrl_r;
    en1_nxt   = en1_r;
    en5_nxt   = en5_r;
    en6_nxt   = en6_r;
    spen_nxt  = spen_r;
    stat_nxt  = stat_r;
    pd_nxt    = 1'b0;
    // Control bits 3:1 are plain storage; bit 4 and the actions never stick
    if (wr_ctrl) begin
      ctrl_nxt = reg_wdata[3:0];
    end
    if (wdt_timeout) begin
      ctrl_nxt[CTRL_WDT_STAT] = 1'b1;
    end
    if (reg_wr) begin
      unique case (eff_idx)
        IDX_DELAY:    delay_nxt = reg_wdata;
        IDX_G1_IRQEN: en1_nxt   = reg_wdata;
        IDX_G5_IRQEN: en5_nxt   = reg_wdata[4:0];
        IDX_G6_IRQEN: en6_nxt   = reg_wdata;
        IDX_SP_EN:    spen_nxt  = reg_wdata[0];
        IDX_SP_STAT:  stat_nxt  = stat_r & ~reg_wdata[1:0];
        default:      ;
      endcase
    end
    // Countdown; force beats abort, abort beats rearm
    if (force_req) begin
      state_nxt = ST_IDLE;
      pd_nxt    = 1'b1;
    end else if (abort_req) begin
      state_nxt = ST_IDLE;
    end else if (rearm_req || (state_r == ST_IDLE && btn_fall && spen_r)) begin
      state_nxt = ST_RUN;
      unit_nxt  = delay_r;
      pre_nxt   = PW'(UNIT_CYCLES - 1);
    end else if (state_r == ST_RUN) begin
      if (pre_r != '0) begin
        pre_nxt = pre_r - PW'(1);
      end else if (unit_r != 8'h00) begin
        unit_nxt = unit_r - 8'h01;
        pre_nxt  = PW'(UNIT_CYCLES - 1);
      end else begin
        state_nxt = ST_IDLE;
        pd_nxt    = 1'b1;
      end
    end
    // Hardware set wins over a simultaneous software clear
    if (pd_nxt) begin
      stat_nxt[STAT_SOFT_OFF] = 1'b1;
    end
    if (btn_fall) begin
      stat_nxt[STAT_BUTTON] = 1'b1;
    end
    irqa_nxt = |(g1_s & en1_r);
    irqb_nxt = |(g5_s & en5_r) | |(g6_s & en6_r);
  end

  // Read mux; pins are taken in the read cycle itself
  always_comb begin
    unique case (eff_idx)
      IDX_CTRL:     rd_mux = {3'b000, 1'b0, ctrl_r[3:1],
                              ctrl_r[CTRL_WDT_STAT]};
      IDX_G1_LVL:   rd_mux = g1_s;
      IDX_G5_LVL:   rd_mux = {3'b000, g5_s};
      IDX_G6_LVL:   rd_mux = g6_s;
      IDX_DELAY:    rd_mux = delay_r;
      IDX_G1_IRQEN: rd_mux = en1_r;
      IDX_G5_IRQEN: rd_mux = {3'b000, en5_r};
      IDX_G6_IRQEN: rd_mux = en6_r;
      IDX_SP_EN:    rd_mux = {7'h00, spen_r};
      IDX_SP_STAT:  rd_mux = {6'h00, stat_r};
      default:      rd_mux = 8'h00;
    endcase
    if (eff_idx == IDX_CTRL) begin
      rd_mux[CTRL_ABORT] = (state_r == ST_IDLE);
    end
    rdata_nxt = reg_rd ? rd_mux : reg_rdata;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r            <= ST_IDLE;
      pre_r              <= '0;
      unit_r             <= 8'h00;
      delay_r            <= DELAY_RST;
      ctrl_r             <= 4'h0;
      en1_r              <= 8'h00;
      en5_r              <= 5'h00;
      en6_r              <= 8'h00;
      spen_r             <= SP_EN_RST[0];
      stat_r             <= 2'b00;
      power_down         <= 1'b0;
      combined_pin_irq_a <= 1'b0;
      combined_pin_irq_b <= 1'b0;
      reg_rdata          <= 8'h00;
    end else if (ce) begin
      state_r            <= state_nxt;
      pre_r              <= pre_nxt;
      unit_r             <= unit_nxt;
      delay_r            <= delay_nxt;
      ctrl_r             <= ctrl_nxt;
      en1_r              <= en1_nxt;
      en5_r              <= en5_nxt;
      en6_r              <= en6_nxt;
      spen_r             <= spen_nxt;
      stat_r             <= stat_nxt;
      power_down         <= pd_nxt;
      combined_pin_irq_a <= irqa_nxt;
      combined_pin_irq_b <= irqb_nxt;
      reg_rdata          <= rdata_nxt;
    end else begin
      power_down         <= 1'b0;
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_abort;
    ce && abort_req && !force_req |=> state_r == ST_IDLE && !power_down;
  endproperty
  a_abort: assert property (p_abort) else $error("abort failed");

  property p_abort_read;
    ce && reg_rd && eff_idx == IDX_CTRL
      |=> reg_rdata[CTRL_ABORT] == ($past(state_r) == ST_IDLE);
  endproperty
  a_abort_read: assert property (p_abort_read) else $error("bit 5");

  property p_rearm;
    ce && rearm_req && !abort_req && !force_req
      |=> state_r == ST_RUN && unit_r == $past(delay_r);
  endproperty
  a_rearm: assert property (p_rearm) else $error("rearm failed");

  property p_rearm_again;
    ce && state_r == ST_RUN && rearm_req && !abort_req && !force_req
      |=> pre_r == PW'(UNIT_CYCLES - 1) && !power_down;
  endproperty
  a_rearm_again: assert property (p_rearm_again) else $error("rearm");

  property p_force;
    ce && force_req |=> power_down && stat_r[STAT_SOFT_OFF];
  endproperty
  a_force: assert property (p_force) else $error("force failed");

  property p_delay_src;
    ce && state_r == ST_IDLE && btn_fall && spen_r && !wr_ctrl
      |=> state_r == ST_RUN && unit_r == $past(delay_r);
  endproperty
  a_delay_src: assert property (p_delay_src) else $error("delay");

  property p_rb1;
    ce && reg_rd && eff_idx == IDX_G1_LVL |=> reg_rdata == $past(g1_s);
  endproperty
  a_rb1: assert property (p_rb1) else $error("group1 readback");

  property p_rb5;
    ce && reg_rd && eff_idx == IDX_G5_LVL
      |=> reg_rdata == {3'b000, $past(g5_s)};
  endproperty
  a_rb5: assert property (p_rb5) else $error("group5 readback");

  property p_rb6;
    ce && reg_rd && eff_idx == IDX_G6_LVL |=> reg_rdata == $past(g6_s);
  endproperty
  a_rb6: assert property (p_rb6) else $error("group6 readback");

  property p_alias;
    ce && !cfg_mode && reg_rd && reg_idx == RT_G6_LVL
      |=> reg_rdata == $past(g6_s);
  endproperty
  a_alias: assert property (p_alias) else $error("alias failed");

  property p_irq_a;
    ce |=> combined_pin_irq_a == |($past(g1_s) & $past(en1_r));
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("irq a");

  property p_irq_b;
    ce && en5_r == 5'h00 && en6_r == 8'h00 |=> !combined_pin_irq_b;
  endproperty
  a_irq_b: assert property (p_irq_b) else $error("irq b");
endmodule
`default_nettype wire

// ---- shared/gsp_pkg.sv ----
// Constants for the pin readback and soft power control block.
// Assumes a 25 MHz core clock and an indexed 8-bit register port.
`default_nettype none
package gsp_pkg;
  // ****************************************************
  // Configuration-mode register indices
  // ****************************************************
  localparam logic [7:0] IDX_CTRL     = 8'hF4;
  localparam logic [7:0] IDX_G1_LVL   = 8'hF6;
  localparam logic [7:0] IDX_G5_LVL   = 8'hF9;
  localparam logic [7:0] IDX_G6_LVL   = 8'hFA;
  localparam logic [7:0] IDX_DELAY    = 8'hB8;
  localparam logic [7:0] IDX_G1_IRQEN = 8'hE0;
  localparam logic [7:0] IDX_G5_IRQEN = 8'hE1;
  localparam logic [7:0] IDX_G6_IRQEN = 8'hE2;
  localparam logic [7:0] IDX_SP_EN    = 8'hE3;
  localparam logic [7:0] IDX_SP_STAT  = 8'hE4;
  localparam logic [7:0] IDX_NONE     = 8'h00;
  // ****************************************************
  // Run-mode alias indices
  // ****************************************************
  localparam logic [7:0] RT_G1_LVL  = 8'h01;
  localparam logic [7:0] RT_CTRL    = 8'h02;
  localparam logic [7:0] RT_G5_LVL  = 8'h03;
  localparam logic [7:0] RT_G6_LVL  = 8'h04;
  localparam logic [7:0] RT_SP_EN   = 8'h05;
  localparam logic [7:0] RT_SP_STAT = 8'h06;
  // ****************************************************
  // Control and soft-power status register fields
  // ****************************************************
  localparam int CTRL_WDT_STAT = 0;
  localparam int CTRL_ABORT    = 5;
  localparam int CTRL_REARM    = 6;
  localparam int CTRL_FORCE    = 7;
  localparam int STAT_SOFT_OFF = 0;
  localparam int STAT_BUTTON   = 1;
  // ****************************************************
  // Reset values and timing
  // ****************************************************
  localparam logic [7:0] DELAY_RST   = 8'h32;
  localparam logic [7:0] SP_EN_RST   = 8'h01;
  localparam int CLK_HZ              = 25_000_000;
  localparam int DELAY_UNIT_MS       = 10;
  localparam int DELAY_DEFAULT_MS    = 500;
  localparam int UNIT_CYCLES_DFLT    = CLK_HZ / 1000 * DELAY_UNIT_MS;
endpackage
`default_nettype wire

// ---- test/gsp_pin_model.sv ----
// Far-side model of the pins and the power button seen by the block.
// Assumes the bench sets the level pattern and the press request.
`default_nettype none
module gsp_pin_model (
  input  wire logic [7:0] pattern,        // Level pattern to present
  input  wire logic       press,          // Hold the button down
  output logic      [7:0] group1_pins,    // Group-1 levels
  output logic      [4:0] group5_pins,    // Group-5 levels
  output logic      [7:0] group6_pins,    // Group-6 levels
  output logic            power_button_n  // Button, active low
);
  timeunit 1ns;
  timeprecision 1ns;
  // Each group gets a different spread so crossed lanes show up
  assign group1_pins    = pattern;
  assign group5_pins    = ~pattern[4:0];
  assign group6_pins    = {pattern[3:0], pattern[7:4]};
  assign power_button_n = ~press;
endmodule
`default_nettype wire

// ---- test/tb_gsp_ctrl.sv ----
// Self-checking bench for the pin readback and soft power control block.
// Assumes the design package and the pin model are compiled first.
`default_nettype none
module tb_gsp_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import gsp_pkg::*;
  logic       core_clk = 1'b0, rstn = 1'b0, cfg_mode = 1'b1;
  logic       reg_wr = 1'b0, reg_rd = 1'b0, press = 1'b0, wdt_timeout = 1'b0;
  logic [7:0] reg_idx = 8'h00, reg_wdata = 8'h00, reg_rdata, pattern = 8'hA5;
  logic [7:0] g1, g6;
  logic [4:0] g5;
  logic       pbn, power_down, irq_a, irq_b;
  int         mismatches = 0, checks_done = 0, pd_count = 0, n, base;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (power_down === 1'b1) pd_count++;
  gsp_pin_model gsp_pin_model_inst (.pattern(pattern),
    .press(press), .group1_pins(g1), .group5_pins(g5), .group6_pins(g6),
    .power_button_n(pbn));
  // Short unit keeps every countdown to a few dozen cycles
  gsp_ctrl #(.UNIT_CYCLES(4)) gsp_ctrl_inst (.core_clk(core_clk),
    .rstn(rstn), .ce(1'b1), .cfg_mode(cfg_mode), .reg_idx(reg_idx),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .group1_pins(g1), .group5_pins(g5),
    .group6_pins(g6), .power_button_n(pbn), .wdt_timeout(wdt_timeout),
    .power_down(power_down), .combined_pin_irq_a(irq_a),
    .combined_pin_irq_b(irq_b));
  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    tick(1);
    reg_idx = idx;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
    tick(1);
    reg_idx = idx;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk($sformatf("read %h", idx), e, reg_rdata);
  endtask
  task automatic wait_pd(output int cnt);
    base = pd_count;
    for (cnt = 1; cnt <= 40 && pd_count == base; cnt++) tick(1);
    if (pd_count == base) begin
      mismatches++;
      $display("mismatch power_down expected pulse seen none");
      finish_test();
    end
  endtask
  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_reset();
    rdchk(IDX_CTRL, 8'h20);
    rdchk(IDX_DELAY, DELAY_RST);
    rdchk(8'h77, 8'h00);
  endtask
  task automatic t_readback();
    rdchk(IDX_G1_LVL, pattern);
    rdchk(IDX_G5_LVL, {3'b000, ~pattern[4:0]});
    rdchk(IDX_G6_LVL, {pattern[3:0], pattern[7:4]});
    wr(IDX_G1_LVL, 8'hFF);
    rdchk(IDX_G1_LVL, pattern);
    cfg_mode = 1'b0;
    rdchk(RT_G1_LVL, pattern);
    rdchk(RT_CTRL, 8'h20);
    rdchk(RT_G5_LVL, {3'b000, ~pattern[4:0]});
    rdchk(RT_G6_LVL, {pattern[3:0], pattern[7:4]});
    cfg_mode = 1'b1;
    // New levels must show at the next read, not a stale copy
    pattern = 8'h3C;
    tick(2);
    rdchk(IDX_G1_LVL, 8'h3C);
    rdchk(IDX_G6_LVL, 8'hC3);
    pattern = 8'hA5;
  endtask
  task automatic t_rearm();
    wr(IDX_DELAY, 8'h02);
    wr(IDX_CTRL, 8'h40);
    rdchk(IDX_CTRL, 8'h00);
    base = pd_count;
    repeat (4) begin
      tick(5);
      wr(IDX_CTRL, 8'h40);
    end
    chk("pulses while rearming", 8'(base), 8'(pd_count));
    wait_pd(n);
    // Delay of 2 units of 4 cycles gives (2+1)*4 cycles
    chk("expiry in 11..14", 8'h01, {7'h00, n >= 11 && n <= 14});
    rdchk(IDX_CTRL, 8'h20);
  endtask
  task automatic t_abort();
    wr(IDX_CTRL, 8'h40);
    tick(3);
    wr(IDX_CTRL, 8'h20);
    rdchk(IDX_CTRL, 8'h20);
    base = pd_count;
    tick(20);
    chk("pulses after abort", 8'(base), 8'(pd_count));
  endtask
  task automatic t_force();
    wr(IDX_CTRL, 8'h80);
    wait_pd(n);
    chk("force latency", 8'h01, {7'h00, n <= 2});
    tick(4);
    chk("force pulse count", 8'(base + 1), 8'(pd_count));
    rdchk(IDX_CTRL, 8'h20);
  endtask
  task automatic t_button();
    press = 1'b1;
    tick(6);
    press = 1'b0;
    rdchk(IDX_CTRL, 8'h00);
    wr(IDX_CTRL, 8'h20);
    rdchk(IDX_CTRL, 8'h20);
    // Soft-off and button-seen flags, read through the run-mode alias
    cfg_mode = 1'b0;
    rdchk(RT_SP_STAT, 8'h03);
    cfg_mode = 1'b1;
  endtask
  task automatic irqchk(input logic [7:0] idx, input logic [7:0] d,
                        input logic ea, input logic eb);
    wr(idx, d);
    tick(4);
    chk("irq a", {7'h00, ea}, {7'h00, irq_a});
    chk("irq b", {7'h00, eb}, {7'h00, irq_b});
  endtask
  task automatic t_irq();
    irqchk(IDX_G1_IRQEN, 8'h01, 1'b1, 1'b0);
    irqchk(IDX_G1_IRQEN, 8'h02, 1'b0, 1'b0);
    irqchk(IDX_G5_IRQEN, 8'h01, 1'b0, 1'b0);
    irqchk(IDX_G5_IRQEN, 8'h02, 1'b0, 1'b1);
    irqchk(IDX_G5_IRQEN, 8'h00, 1'b0, 1'b0);
    irqchk(IDX_G6_IRQEN, 8'h02, 1'b0, 1'b1);
    irqchk(IDX_G6_IRQEN, 8'h01, 1'b0, 1'b0);
  endtask
  task automatic t_wdt();
    wdt_timeout = 1'b1;
    tick(1);
    wdt_timeout = 1'b0;
    rdchk(IDX_CTRL, 8'h21);
    wr(IDX_CTRL, 8'h00);
    rdchk(IDX_CTRL, 8'h20);
  endtask
  initial begin
    tick(3);
    rstn = 1'b1;
    t_reset();
    t_readback();
    t_rearm();
    t_abort();
    t_force();
    t_button();
    t_irq();
    t_wdt();
    finish_test();
  end
endmodule
`default_nettype wire
